// File: pcs_decoder_model.sv
// decoder model: one request pulse for each bench opcode
`timescale 1ns/1ps
module pcs_decoder_model (
    input wire logic [3:0] op,
    output logic [9:0] req
);
    // ====
    // decode
    // no push or pop opcode: only call, exits and vectoring move the stack
    assign req = 10'h001 << op;
endmodule // pcs_decoder_model

// File: pcs_pc_stack.sv
// program counter sequencing with an eight deep circular return stack
`timescale 1ns/1ps
// What this block does
// - keeps a 13-bit program counter that addresses program memory.
// - low byte read/write via low-byte register; upper five bits come from latch.
// - every reset clears the whole program counter to zero.
// - low-byte write loads latch bits 4:0 into upper bits at once.
// - call or jump takes top two counter bits from latch bits 4:3.
// - eight-entry return stack, each entry a full 13-bit value.
// - stack outside address spaces; pointer not readable or writable.
// - push counter on call and on interrupt vectoring.
// - pop on subroutine exit, literal exit and interrupt exit.
// - push and pop leave the high latch register unchanged.
// - stack is circular; ninth push overwrites the first.
// - no overflow or underflow flag exists.
// - push and pop happen only implicitly through call, return, interrupt.
module pcs_pc_stack import pcs_pkg::*; #(
    parameter logic [12:0] INT_VECTOR = PCS_INT_VECTOR
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic low_write,
    input wire logic [7:0] low_write_data,
    input wire logic latch_write,
    input wire logic [7:0] latch_write_data,
    input wire logic jump_instr,
    input wire logic call_instr,
    input wire logic [10:0] target,
    input wire logic return_instr,
    input wire logic literal_exit_instr,
    input wire logic interrupt_exit_instr,
    input wire logic int_vector_take,
    output logic [12:0] pc,
    output logic [7:0] counter_low_byte_reg,
    output logic [7:0] counter_high_latch_reg
);
    // ========================================
    // state
    typedef struct packed {
        logic [12:0] pc;
        logic [7:0] latch;
        logic [2:0] sp;
        logic ret_pending;
    } pcs_state_t;

    pcs_state_t state_reg;
    pcs_state_t state_next;
    pcs_act_t act;
    logic push;
    logic [12:0] push_data;
    logic [2:0] top_idx;
    logic [12:0] top_data;
    logic pop;

    // ========================================
    // action select: interrupt wins, then control flow, then writes
    always_comb begin
        pop = return_instr | literal_exit_instr | interrupt_exit_instr;
        if (int_vector_take) begin
            act = PCS_ACT_INT;
        end else if (pop) begin
            act = PCS_ACT_RET;
        end else if (call_instr) begin
            act = PCS_ACT_CALL;
        end else if (jump_instr) begin
            act = PCS_ACT_JUMP;
        end else if (low_write) begin
            act = PCS_ACT_LOW_WRITE;
        end else if (step) begin
            act = PCS_ACT_STEP;
        end else begin
            act = PCS_ACT_HOLD;
        end
    end

    // the return address is the counter of the caller plus one
    assign push = (act == PCS_ACT_CALL) || (act == PCS_ACT_INT);
    assign push_data = state_reg.pc + 13'h0001;
    // pointer names the next free slot; wraps silently, no flags
    assign top_idx = state_reg.sp - 3'h1;

    // ========================================
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.ret_pending = 1'b0;
        unique case (act)
            PCS_ACT_STEP: begin
                // plain advance; low byte carries into the upper bits here only
                state_next.pc = state_reg.pc + 13'h0001;
            end
            PCS_ACT_LOW_WRITE: begin
                // no carry help for computed jumps: software owns the latch
                state_next.pc = {state_reg.latch[PCS_LATCH_FULL_LSB +: PCS_HIGH_WIDTH],
                    low_write_data};
            end
            PCS_ACT_JUMP: begin
                state_next.pc = {state_reg.latch[PCS_LATCH_PAGE_LSB +: PCS_LATCH_PAGE_WIDTH],
                    target};
            end
            PCS_ACT_CALL: begin
                state_next.pc = {state_reg.latch[PCS_LATCH_PAGE_LSB +: PCS_LATCH_PAGE_WIDTH],
                    target};
                state_next.sp = state_reg.sp + 3'h1;
            end
            PCS_ACT_INT: begin
                state_next.pc = INT_VECTOR;
                state_next.sp = state_reg.sp + 3'h1;
            end
            PCS_ACT_RET: begin
                state_next.sp = top_idx;
                state_next.ret_pending = 1'b1;
            end
            PCS_ACT_HOLD: begin
                state_next.pc = state_reg.pc;
            end
        endcase
        // registered stack read lands one cycle after the pop
        if (state_reg.ret_pending) begin
            state_next.pc = top_data;
        end
        // latch only changes by its own write, never by push or pop
        if (latch_write) begin
            state_next.latch = latch_write_data;
        end
    end

    // ========================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.pc <= PCS_PC_RESET;
            state_reg.latch <= PCS_LATCH_RESET;
            state_reg.sp <= PCS_SP_RESET;
            state_reg.ret_pending <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ========================================
    // return stack, private to this block
    pcs_stack_mem #(
        .WIDTH(PCS_PC_WIDTH),
        .DEPTH(PCS_STACK_DEPTH),
        .AW(PCS_SP_WIDTH)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .wr_en(push),
        .wr_addr(state_reg.sp),
        .wr_data(push_data),
        .rd_addr(top_idx),
        .rd_data(top_data)
    );

    assign pc = state_reg.pc;
    assign counter_low_byte_reg = state_reg.pc[7:0];
    assign counter_high_latch_reg = state_reg.latch;
endmodule // pcs_pc_stack

// File: pcs_pc_stack_properties.sv
// checker: port properties of the program counter and return stack
`timescale 1ns/1ps
module pcs_pc_stack_properties import pcs_pkg::*; #(
    parameter logic [12:0] INT_VECTOR = PCS_INT_VECTOR
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic low_write,
    input wire logic [7:0] low_write_data,
    input wire logic latch_write,
    input wire logic jump_instr,
    input wire logic call_instr,
    input wire logic [10:0] target,
    input wire logic return_instr,
    input wire logic literal_exit_instr,
    input wire logic interrupt_exit_instr,
    input wire logic int_vector_take,
    input wire logic [12:0] pc,
    input wire logic [7:0] counter_low_byte_reg,
    input wire logic [7:0] counter_high_latch_reg
);
    // ====
    // properties
    wire pop = return_instr | literal_exit_instr | interrupt_exit_instr;
    wire hi = pop | int_vector_take;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // the cycle after a pop is owned by the return load, so it is excluded
    sequence s_call; call_instr && !hi && !$past(pop); endsequence
    sequence s_pop; pop && !int_vector_take; endsequence
    a_reset_clear: assert property (disable iff (1'b0) rst
        |=> pc == 13'h0000 && counter_high_latch_reg == 8'h00) else $error("reset");
    a_low_mirror: assert property (counter_low_byte_reg == pc[7:0])
        else $error("low byte");
    a_low_load: assert property (low_write && !hi && !jump_instr && !call_instr
        && !$past(pop) |=> pc == {$past(counter_high_latch_reg[4:0]), $past(low_write_data)})
        else $error("low write");
    a_page_load: assert property ((jump_instr || call_instr) && !hi && !$past(pop)
        |=> pc == {$past(counter_high_latch_reg[4:3]), $past(target)}) else $error("jump");
    a_int_vec: assert property (int_vector_take && !$past(pop) |=> pc == INT_VECTOR)
        else $error("vector");
    a_call_ret: assert property (s_call ##1 s_pop |=> ##1 pc == $past(pc, 3) + 13'h0001)
        else $error("return");
    a_pop_hold: assert property (pop && !int_vector_take && !$past(pop)
        |=> $stable(pc)) else $error("pop gap");
    a_latch_keep: assert property ((hi || call_instr) && !latch_write
        |=> $stable(counter_high_latch_reg)) else $error("latch");
    a_step_one: assert property (step && !hi && !low_write && !jump_instr && !call_instr
        && !$past(pop) |=> pc == $past(pc) + 13'h0001) else $error("step");
endmodule // pcs_pc_stack_properties
bind pcs_pc_stack pcs_pc_stack_properties #(.INT_VECTOR(INT_VECTOR)) u_props (.*);

// File: pcs_pkg.sv
// package: constants for the program counter and return stack
package pcs_pkg;
    localparam int PCS_PC_WIDTH = 13;
    localparam int PCS_LOW_WIDTH = 8;
    localparam int PCS_HIGH_WIDTH = 5;
    localparam int PCS_TARGET_WIDTH = 11;
    localparam int PCS_STACK_DEPTH = 8;
    localparam int PCS_SP_WIDTH = 3;
    localparam logic [12:0] PCS_PC_RESET = 13'h0000;
    localparam logic [7:0] PCS_LATCH_RESET = 8'h00;
    localparam logic [2:0] PCS_SP_RESET = 3'h0;
    localparam logic [12:0] PCS_INT_VECTOR = 13'h0004;
    localparam int PCS_LATCH_FULL_LSB = 0;
    localparam int PCS_LATCH_PAGE_LSB = 3;
    localparam int PCS_LATCH_PAGE_WIDTH = 2;

    // one-hot sequencing action chosen each cycle
    typedef enum logic [6:0] {
        PCS_ACT_STEP = 7'h01,
        PCS_ACT_LOW_WRITE = 7'h02,
        PCS_ACT_JUMP = 7'h04,
        PCS_ACT_CALL = 7'h08,
        PCS_ACT_INT = 7'h10,
        PCS_ACT_RET = 7'h20,
        PCS_ACT_HOLD = 7'h40
    } pcs_act_t;
endpackage

// File: pcs_stack_mem.sv
// return address store: small register array, registered read data
`timescale 1ns/1ps
module pcs_stack_mem import pcs_pkg::*; #(
    parameter int WIDTH = PCS_PC_WIDTH,
    parameter int DEPTH = PCS_STACK_DEPTH,
    parameter int AW = PCS_SP_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } pcs_mem_state_t;

    pcs_mem_state_t state_reg;
    pcs_mem_state_t state_next;

    // ========================================
    // next state
    always_comb begin
        state_next = state_reg;
        if (wr_en) begin
            state_next.mem[wr_addr] = wr_data;
        end
        // write-through so a read of the slot being written sees new data
        if (wr_en && (wr_addr == rd_addr)) begin
            state_next.rd = wr_data;
        end else begin
            state_next.rd = state_next.mem[rd_addr];
        end
    end

    // ========================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.rd;
endmodule // pcs_stack_mem

// File: test_program_counter_and_call_stack.sv
// testbench: program counter and return stack scenarios
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module test_program_counter_and_call_stack import pcs_pkg::*; ;
    // ====
    // stimulus and notes
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] op = 4'h0;
    logic [10:0] dat = 11'h000;
    logic [9:0] req;
    logic [12:0] pc, pcx, stk [8];
    logic [7:0] low, lat, lx;
    logic [2:0] sp;
    logic [20:0] q [$];
    logic [20:0] e;
    int seed = 32'h3B6A, error_cnt = 0, checks = 0, i;
    pcs_decoder_model u_dec (.op(op), .req(req));
    pcs_pc_stack dut (.clk(clk), .rst(rst), .step(req[1]), .low_write(req[2]),
        .low_write_data(dat[7:0]), .latch_write(req[3]), .latch_write_data(dat[7:0]),
        .jump_instr(req[4]), .call_instr(req[5]), .target(dat), .return_instr(req[6]),
        .literal_exit_instr(req[7]), .interrupt_exit_instr(req[8]),
        .int_vector_take(req[9]), .pc(pc), .counter_low_byte_reg(low),
        .counter_high_latch_reg(lat));
    initial forever #4 clk = ~clk;
    always @(negedge clk) if (q.size() > 0) begin
        e = q.pop_front();
        `CHK("pc", e, {lat, pc})
        `CHK("low byte", e[7:0], low)
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a pop leaves its follow-up cycle idle, since the return load owns it
    task automatic run(input logic [3:0] o);
        dat <= 11'($random(seed));
        op <= o;
        @(posedge clk);
        case (o)
            4'h1: pcx = pcx + 13'h0001;
            4'h2: pcx = {lx[4:0], dat[7:0]};
            4'h3: lx = dat[7:0];
            4'h4: pcx = {lx[4:3], dat};
            4'h5, 4'h9: begin
                stk[sp] = pcx + 13'h0001;
                sp = sp + 3'h1;
                pcx = (o == 4'h5) ? {lx[4:3], dat} : PCS_INT_VECTOR;
            end
            default: begin
                // pc must still show the old value in the return gap
                q.push_back({lx, pcx});
                op <= 4'h0;
                @(posedge clk);
                sp = sp - 3'h1;
                pcx = stk[sp];
            end
        endcase
        q.push_back({lx, pcx});
    endtask
    task automatic reset_all;
        op <= 4'h0;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        pcx = 13'h0000;
        lx = 8'h00;
        sp = 3'h0;
        q.push_back(21'h0);
    endtask
    initial begin
        reset_all();
        for (i = 1; i < 5; i++) run(4'(i));
        for (i = 0; i < 9; i++) run(4'h5);
        for (i = 0; i < 9; i++) run(4'(6 + i % 3));
        run(4'h9);
        run(4'h8);
        $display("directed test done");
        for (i = 0; i < 60; i++) run(4'(1 + {$random(seed)} % 9));
        $display("random test done");
        reset_all();
        run(4'h5);
        run(4'h7);
        op <= 4'h0;
        repeat (3) @(posedge clk);
        $display("reset test done");
        print_verdict();
    end
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule // test_program_counter_and_call_stack
